// [logic/msrb_bank.sv]
/*
 Register bank of a two-channel DC motor stage, both channel sets in one.
 Assumes synchronous register strobes and measured values from the drive core.
*/
`timescale 1ns/1ps

module msrb_bank #(
	parameter int unsigned       WD_LIMIT  = msrb_pkg::WD_CYCLES,
	parameter int unsigned       QUIET_LEN = 16,
	parameter logic [15:0]       TYPE_ID   = 16'h0a5a,
	parameter logic [15:0]       FW_ASCII  = 16'h3130
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        reg_ch,
	input  wire logic [5:0]                  reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [15:0]                 reg_wdata,
	output      logic [15:0]                 reg_rdata,
	output      logic                        reg_ack,
	input  wire msrb_pkg::msrb_meas_t        meas,
	input  wire msrb_pkg::msrb_factory_t     factory,
	input  wire msrb_pkg::msrb_chan_in_t     chan_in [2],
	output      msrb_pkg::msrb_chan_out_t    chan_out [2]
);
	// TYPE_ID value is arbitrary.

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]              sel;
		logic [15:0]              page;
		logic [15:0]              preset;
		logic [15:0]              cmd;
		logic [15:0]              code;
		logic [15:0]              feat1;
		logic [15:0]              feat2;
		logic [15:0]              r48;
		logic [15:0]              r50;
		logic [15:0]              r51;
		logic                     cb_prev;
		logic [23:0]              wd_cnt;
		logic [15:0]              quiet;
		msrb_pkg::msrb_chan_out_t o;
	} msrb_chan_t;

	typedef struct packed {
		msrb_chan_t [1:0] ch;
		logic [15:0]      rdata;
		logic             ack;
	} msrb_state_t;

	msrb_state_t st_q;
	msrb_state_t st_d;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] pick_meas(input logic [7:0] code);
		logic [15:0] v;
		v = 16'h0000;
		if (code <= msrb_pkg::SEL_LAST) begin
			v = meas.val[code[3:0]];
		end else if (code == msrb_pkg::SEL_DRV_FW) begin
			v = meas.drv_fw;
		end
		return v;
	endfunction

	function automatic logic [15:0] read_reg(input msrb_chan_t c, input logic [7:0] sbyte);
		logic [15:0] v;
		logic [5:0]  idx;
		v = 16'h0000;
		idx = reg_addr - msrb_pkg::A_UPPER;
		if (reg_addr >= msrb_pkg::A_UPPER && c.page[0]) begin
			if (idx < 6'(msrb_pkg::N_MEAS)) begin
				v = meas.val[idx[3:0]];
			end
		end else begin
			case (reg_addr)
				msrb_pkg::A_SEL:    v = c.sel;
				msrb_pkg::A_MEAS_A: v = pick_meas(c.sel[7:0]);
				msrb_pkg::A_MEAS_B: v = pick_meas(c.sel[15:8]);
				msrb_pkg::A_PAGE:   v = c.page;
				msrb_pkg::A_PRESET: v = c.preset;
				msrb_pkg::A_STATUS: v = {8'h00, sbyte};
				msrb_pkg::A_CMD:    v = c.cmd;
				msrb_pkg::A_TYPE:   v = TYPE_ID;
				msrb_pkg::A_FW:     v = FW_ASCII;
				msrb_pkg::A_HW:     v = factory.hw_rev;
				msrb_pkg::A_LINKF:  v = factory.link_freq;
				msrb_pkg::A_DEAD:   v = factory.dead_time;
				msrb_pkg::A_DUTY:   v = factory.duty_lim;
				msrb_pkg::A_TEMP:   v = factory.temp_thr;
				msrb_pkg::A_ADC:    v = factory.adc_time;
				msrb_pkg::A_CODE:   v = c.code;
				msrb_pkg::A_FEAT1:  v = c.feat1;
				msrb_pkg::A_FEAT2:  v = c.feat2;
				msrb_pkg::A_R48:    v = c.r48;
				msrb_pkg::A_R50:    v = c.r50;
				msrb_pkg::A_R51:    v = c.r51;
				default:            v = 16'h0000;
			endcase
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       restore;
		logic [1:0] swrst;
		logic       unlocked;
		logic       hit;
		logic [1:0] trip_set;
		restore = 1'b0;
		swrst = 2'b00;
		unlocked = 1'b0;
		hit = 1'b0;
		trip_set = 2'b00;
		st_d = st_q;
		st_d.ack = reg_wr | reg_rd;
		if (reg_rd) begin
			st_d.rdata = read_reg(st_q.ch[reg_ch], chan_in[reg_ch].status_byte);
		end

		for (int c = 0; c < 2; c++) begin
			st_d.ch[c].o.cnt_load = 1'b0;
			st_d.ch[c].o.drv_reinit = 1'b0;

			// Preset strobe edge detection.
			st_d.ch[c].cb_prev = chan_in[c].ctrl_byte[msrb_pkg::CB_PRESET];
			if (chan_in[c].ctrl_byte[msrb_pkg::CB_PRESET] && !st_q.ch[c].cb_prev) begin
				st_d.ch[c].o.cnt_load = 1'b1;
				st_d.ch[c].o.cnt_val = st_q.ch[c].preset;
			end

			// A kick or a quiet period restarts the timeout, so a software reset never trips it; after the reset input it runs at once.
			if (st_q.ch[c].feat1[msrb_pkg::B_WDOFF] || chan_in[c].wd_kick
					|| st_q.ch[c].quiet != 16'h0000) begin
				st_d.ch[c].wd_cnt = 24'h000000;
			end else if (st_q.ch[c].wd_cnt >= 24'(WD_LIMIT - 1)) begin
				st_d.ch[c].o.wd_trip = 1'b1;
				trip_set[c] = 1'b1;
			end else begin
				st_d.ch[c].wd_cnt = st_q.ch[c].wd_cnt + 24'h000001;
			end

			st_d.ch[c].o.overload_warn = chan_in[c].overload
				& ~st_q.ch[c].feat1[msrb_pkg::B_OCERR];
			if (chan_in[c].overload && st_q.ch[c].feat1[msrb_pkg::B_OCERR]) begin
				st_d.ch[c].o.fault = 1'b1;
			end

			st_d.ch[c].o.torque_cut = st_q.ch[c].feat1[msrb_pkg::B_AUTO]
				? chan_in[c].auto_req
				: chan_in[c].ctrl_byte[msrb_pkg::CB_TORQUE];
			st_d.ch[c].o.encoder_filter_off = st_q.ch[c].feat1[msrb_pkg::B_FILT];

			if (st_q.ch[c].quiet != 16'h0000) begin
				st_d.ch[c].quiet = st_q.ch[c].quiet - 16'h0001;
			end

			// Register writes, one channel set per access; a restore command resets the upper registers of both channel sets.
			hit = reg_wr && (reg_ch == 1'(c));
			unlocked = (st_q.ch[c].code == msrb_pkg::CODE_WORD);
			if (hit && reg_addr == msrb_pkg::A_CODE) begin
				st_d.ch[c].code = reg_wdata;
			end else if (hit && unlocked) begin
				if (reg_addr >= msrb_pkg::A_UPPER) begin
					if (!st_q.ch[c].page[0]) begin
						case (reg_addr)
							msrb_pkg::A_FEAT1:
								st_d.ch[c].feat1 = reg_wdata & msrb_pkg::FEAT1_MASK;
							msrb_pkg::A_FEAT2: st_d.ch[c].feat2 = reg_wdata;
							msrb_pkg::A_R48:   st_d.ch[c].r48 = reg_wdata;
							msrb_pkg::A_R50:   st_d.ch[c].r50 = reg_wdata;
							msrb_pkg::A_R51:   st_d.ch[c].r51 = reg_wdata;
							default:           st_d.ch[c].r51 = st_q.ch[c].r51;
						endcase
					end
				end else begin
					// Identity and manufacturer numbers fall to default: read only.
					case (reg_addr)
						msrb_pkg::A_SEL:    st_d.ch[c].sel = reg_wdata;
						msrb_pkg::A_PAGE:
							st_d.ch[c].page = reg_wdata & msrb_pkg::PAGE_MASK;
						msrb_pkg::A_PRESET: st_d.ch[c].preset = reg_wdata;
						msrb_pkg::A_CMD: begin
							st_d.ch[c].cmd = reg_wdata;
							if (reg_wdata == msrb_pkg::CMD_RESTORE) begin
								restore = 1'b1;
							end
							if (reg_wdata == msrb_pkg::CMD_SWRST) begin
								swrst[c] = 1'b1;
							end
						end
						default:            st_d.ch[c].sel = st_q.ch[c].sel;
					endcase
				end
			end
		end

		// ----------------------------------------------------------------
		// Commands
		// ----------------------------------------------------------------
		for (int c = 0; c < 2; c++) begin
			if (restore) begin
				st_d.ch[c].feat1 = msrb_pkg::DEF_ZERO;
				st_d.ch[c].feat2 = msrb_pkg::DEF_ZERO;
				st_d.ch[c].r48 = msrb_pkg::DEF_R48;
				st_d.ch[c].r50 = msrb_pkg::DEF_R50;
				st_d.ch[c].r51 = msrb_pkg::DEF_R51;
				st_d.ch[c].quiet = 16'(QUIET_LEN);
			end
			if (swrst[c]) begin
				st_d.ch[c].wd_cnt = 24'h000000;
				// A trip or fault raised in this same cycle outlives the reset.
				st_d.ch[c].o.wd_trip = trip_set[c];
				st_d.ch[c].o.fault = chan_in[c].overload
					& st_q.ch[c].feat1[msrb_pkg::B_OCERR];
				st_d.ch[c].o.overload_warn = 1'b0;
				st_d.ch[c].o.cnt_val = 16'h0000;
				st_d.ch[c].o.drv_reinit = 1'b1;
				st_d.ch[c].quiet = 16'(QUIET_LEN);
			end
			st_d.ch[c].o.motor_off = (st_d.ch[c].quiet != 16'h0000);
			st_d.ch[c].o.chan_off = st_d.ch[c].o.motor_off
				| st_d.ch[c].o.fault | st_d.ch[c].o.wd_trip;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Clearing everything also drops the code word, so every reset input restart relocks; the software reset command keeps it.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign reg_ack = st_q.ack;
	assign chan_out[0] = st_q.ch[0].o;
	assign chan_out[1] = st_q.ch[1].o;

endmodule

// [logic/msrb_pkg.sv]
/*
 Shared constants and carrier types of the motor stage register bank.
 Assumes one 100 MHz core clock and a 6-bit register number per channel.
*/
package msrb_pkg;

	// ----------------------------------------------------------------
	// Register numbers
	// ----------------------------------------------------------------
	localparam logic [5:0] A_SEL    = 6'h01;
	localparam logic [5:0] A_MEAS_A = 6'h02;
	localparam logic [5:0] A_MEAS_B = 6'h03;
	localparam logic [5:0] A_PAGE   = 6'h04;
	localparam logic [5:0] A_PRESET = 6'h05;
	localparam logic [5:0] A_STATUS = 6'h06;
	localparam logic [5:0] A_CMD    = 6'h07;
	localparam logic [5:0] A_TYPE   = 6'h08;
	localparam logic [5:0] A_FW     = 6'h09;
	localparam logic [5:0] A_HW     = 6'h10;
	localparam logic [5:0] A_LINKF  = 6'h11;
	localparam logic [5:0] A_DEAD   = 6'h12;
	localparam logic [5:0] A_DUTY   = 6'h13;
	localparam logic [5:0] A_TEMP   = 6'h14;
	localparam logic [5:0] A_ADC    = 6'h15;
	localparam logic [5:0] A_CODE   = 6'h1f;
	localparam logic [5:0] A_FEAT1  = 6'h20;
	localparam logic [5:0] A_FEAT2  = 6'h21;
	localparam logic [5:0] A_R48    = 6'h30;
	localparam logic [5:0] A_R50    = 6'h32;
	localparam logic [5:0] A_R51    = 6'h33;
	localparam logic [5:0] A_UPPER  = 6'h20;

	// ----------------------------------------------------------------
	// Values, fields and defaults
	// ----------------------------------------------------------------
	localparam logic [15:0] CODE_WORD   = 16'h1235;
	localparam logic [15:0] CMD_RESTORE = 16'h7000;
	localparam logic [15:0] CMD_SWRST   = 16'h8000;
	localparam logic [15:0] DEF_ZERO    = 16'h0000;
	localparam logic [15:0] DEF_R48     = 16'h0064;
	localparam logic [15:0] DEF_R50     = 16'h0190;
	localparam logic [15:0] DEF_R51     = 16'h0004;
	localparam logic [15:0] FEAT1_MASK  = 16'h1604;
	localparam logic [15:0] PAGE_MASK   = 16'h0001;
	localparam int unsigned B_FILT      = 12;
	localparam int unsigned B_AUTO      = 10;
	localparam int unsigned B_OCERR     = 9;
	localparam int unsigned B_WDOFF     = 2;
	localparam int unsigned CB_TORQUE   = 0;
	localparam int unsigned CB_PRESET   = 1;
	localparam logic [7:0]  SEL_LAST    = 8'h0e;
	localparam logic [7:0]  SEL_DRV_FW  = 8'hff;
	localparam int unsigned N_MEAS      = 15;
	localparam int unsigned WD_MS       = 100;
	localparam int unsigned CLK_KHZ     = 100000;
	localparam int unsigned WD_CYCLES   = WD_MS * CLK_KHZ;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0]               drv_fw;
		logic [N_MEAS-1:0][15:0]   val;
	} msrb_meas_t;

	typedef struct packed {
		logic [15:0] hw_rev;
		logic [15:0] link_freq;
		logic [15:0] dead_time;
		logic [15:0] duty_lim;
		logic [15:0] temp_thr;
		logic [15:0] adc_time;
	} msrb_factory_t;

	typedef struct packed {
		logic [7:0] ctrl_byte;
		logic [7:0] status_byte;
		logic       overload;
		logic       wd_kick;
		logic       auto_req;
	} msrb_chan_in_t;

	typedef struct packed {
		logic        cnt_load;
		logic [15:0] cnt_val;
		logic        motor_off;
		logic        drv_reinit;
		logic        wd_trip;
		logic        overload_warn;
		logic        fault;
		logic        chan_off;
		logic        torque_cut;
		logic        encoder_filter_off;
	} msrb_chan_out_t;

endpackage

// [verification/msrb_bank_checker.sv]
/*
 Port checker of the motor stage register bank.
 Assumes it is bound to msrb_bank with the same identifier parameter.
*/
`timescale 1ns/1ps
module msrb_bank_checker #(
	parameter logic [15:0] TYPE_ID = 16'h0a5a // Arbitrary value.
) (
	input wire logic                     core_clk,
	input wire logic                     reset,
	input wire logic                     reg_ch,
	input wire logic [5:0]               reg_addr,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [15:0]              reg_rdata,
	input wire msrb_pkg::msrb_factory_t  factory,
	input wire msrb_pkg::msrb_chan_in_t  chan_in [2],
	input wire msrb_pkg::msrb_chan_out_t chan_out [2]
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	logic rd_only;
	assign rd_only = reg_rd && !reg_wr;
	property p_preset;
		$rose(chan_in[1].ctrl_byte[1]) |=> chan_out[1].cnt_load;
	endproperty
	a_preset: assert property (p_preset) else $error("no counter load");
	property p_torque;
		chan_in[0].auto_req == chan_in[0].ctrl_byte[0]
			|=> chan_out[0].torque_cut == $past(chan_in[0].auto_req);
	endproperty
	a_torque: assert property (p_torque) else $error("torque cut wrong");
	property p_quiet;
		chan_out[0].motor_off |-> chan_out[0].chan_off;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs live in reset");
	property p_fault;
		$fell(chan_out[0].fault) |-> ##[0:1] chan_out[0].motor_off;
	endproperty
	a_fault: assert property (p_fault) else $error("fault not sticky");
	property p_status;
		rd_only && reg_ch && reg_addr == msrb_pkg::A_STATUS
			|=> reg_rdata == {8'h00, $past(chan_in[1].status_byte)};
	endproperty
	a_status: assert property (p_status) else $error("status mirror wrong");
	property p_type;
		rd_only && reg_addr == msrb_pkg::A_TYPE |=> reg_rdata == TYPE_ID;
	endproperty
	a_type: assert property (p_type) else $error("type id wrong");
	property p_hw;
		rd_only && reg_addr == msrb_pkg::A_HW |=> reg_rdata == $past(factory.hw_rev);
	endproperty
	a_hw: assert property (p_hw) else $error("hardware version wrong");
	property p_reinit;
		chan_out[0].drv_reinit |=> !chan_out[0].drv_reinit && chan_out[0].motor_off;
	endproperty
	a_reinit: assert property (p_reinit) else $error("reinit pulse wrong");
	c_load: cover property (chan_out[1].cnt_load);
	c_fault: cover property (chan_out[0].fault);
	c_trip: cover property (chan_out[1].wd_trip);
endmodule
bind msrb_bank msrb_bank_checker #(.TYPE_ID(TYPE_ID)) i_chk (.core_clk(core_clk),
	.reset(reset), .reg_ch(reg_ch), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .factory(factory), .chan_in(chan_in),
	.chan_out(chan_out));

// [verification/msrb_host.sv]
/*
 Host model of the register port, one access at a time.
 Assumes the bank answers with reg_ack one cycle after each strobe.
*/
`timescale 1ns/1ps
module msrb_host (
	input  wire logic        core_clk,
	output      logic        reg_ch,
	output      logic [5:0]  reg_addr,
	output      logic        reg_wr,
	output      logic        reg_rd,
	output      logic [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack
);
	initial begin
		reg_ch = 1'b0;
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	// Idle address and data lines show the inverse of the last value, so stale data never looks valid.
	task automatic acc(input logic ch, input logic w, input logic [5:0] a,
		input logic [15:0] d, output logic [15:0] r, output logic k);
		@(negedge core_clk);
		reg_ch = ch;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge core_clk);
		k = reg_ack;
		r = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic unlock(input logic ch);
		logic [15:0] r;
		logic        k;
		acc(ch, 1'b1, msrb_pkg::A_CODE, msrb_pkg::CODE_WORD, r, k);
	endtask
endmodule

// [verification/testbench.sv]
/*
 Self-checking bench of the motor stage register bank.
 Assumes the host model owns the register port and the bench the drive core side.
*/
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] TYPE_V = 16'h0a5a; // Arbitrary value.
	logic                     core_clk, reset, reg_ch, reg_wr, reg_rd, reg_ack;
	logic [5:0]               reg_addr;
	logic [15:0]              reg_wdata, reg_rdata;
	msrb_pkg::msrb_meas_t     meas;
	msrb_pkg::msrb_factory_t  factory;
	msrb_pkg::msrb_chan_in_t  chan_in [2];
	msrb_pkg::msrb_chan_out_t chan_out [2];
	int                       err_total, checks, i;
	// A short watchdog limit keeps the run brief.
	localparam int          WD_SIM = 50;
	msrb_bank #(.WD_LIMIT(WD_SIM), .TYPE_ID(TYPE_V)) i_dut (.core_clk(core_clk), .reset(reset),
		.reg_ch(reg_ch), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .meas(meas),
		.factory(factory), .chan_in(chan_in), .chan_out(chan_out));
	msrb_host i_host (.core_clk(core_clk), .reg_ch(reg_ch), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_ack(reg_ack));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic results();
		if (err_total == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic ch, input logic [5:0] a, input logic [15:0] d);
		logic [15:0] r;
		logic        k;
		i_host.acc(ch, 1'b1, a, d, r, k);
		chk({15'h0, k}, 16'h0001);
	endtask
	task automatic rd(input logic ch, input logic [5:0] a, input logic [15:0] e);
		logic [15:0] r;
		logic        k;
		i_host.acc(ch, 1'b0, a, 16'h0000, r, k);
		chk(r, e);
	endtask
	task automatic do_reset();
		reset = 1'b1;
		repeat (20) @(negedge core_clk);
		reset = 1'b0;
	endtask
	task automatic s_lock();
		wr(1'b0, msrb_pkg::A_FEAT1, 16'h1604);
		rd(1'b0, msrb_pkg::A_FEAT1, 16'h0000);
		wr(1'b0, msrb_pkg::A_CMD, 16'h7000);
		chk({15'h0, chan_out[0].motor_off}, 16'h0000);
	endtask
	task automatic s_ro();
		wr(1'b0, msrb_pkg::A_FW, 16'h0000);
		wr(1'b0, msrb_pkg::A_LINKF, 16'h0000);
		rd(1'b0, msrb_pkg::A_TYPE, TYPE_V);
		rd(1'b0, msrb_pkg::A_FW, 16'h3130);
		rd(1'b0, msrb_pkg::A_HW, factory.hw_rev);
		rd(1'b0, msrb_pkg::A_LINKF, factory.link_freq);
		rd(1'b0, 6'h0e, 16'h0000);
	endtask
	task automatic s_sel();
		for (i = 0; i < 15; i++) begin
			wr(i[0], msrb_pkg::A_SEL, {8'(14 - i), 8'(i)});
			rd(i[0], msrb_pkg::A_MEAS_A, meas.val[i]);
			rd(i[0], msrb_pkg::A_MEAS_B, meas.val[14 - i]);
		end
		wr(1'b1, msrb_pkg::A_SEL, 16'hff0f);
		rd(1'b1, msrb_pkg::A_MEAS_A, 16'h0000);
		rd(1'b1, msrb_pkg::A_MEAS_B, meas.drv_fw);
		wr(1'b0, msrb_pkg::A_SEL, 16'h00fe);
		rd(1'b0, msrb_pkg::A_MEAS_A, 16'h0000);
	endtask
	task automatic s_page();
		rd(1'b0, msrb_pkg::A_PAGE, 16'h0000);
		wr(1'b0, msrb_pkg::A_PAGE, 16'h0001);
		wr(1'b0, msrb_pkg::A_UPPER, 16'h1604);
		rd(1'b0, 6'h23, meas.val[3]);
		wr(1'b0, msrb_pkg::A_PAGE, 16'h0000);
		rd(1'b0, msrb_pkg::A_FEAT1, 16'h0000);
	endtask
	task automatic s_feat();
		wr(1'b0, msrb_pkg::A_FEAT1, 16'hffff);
		wr(1'b1, msrb_pkg::A_FEAT1, 16'h0400);
		chk({15'h0, chan_out[0].encoder_filter_off}, 16'h0001);
		chk({15'h0, chan_out[1].encoder_filter_off}, 16'h0000);
		rd(1'b0, msrb_pkg::A_FEAT1, 16'h1604);
		rd(1'b1, msrb_pkg::A_FEAT1, 16'h0400);
		wr(1'b1, msrb_pkg::A_CMD, 16'h7000);
		chk({14'h0, chan_out[1].motor_off, chan_out[0].motor_off}, 16'h0003);
		rd(1'b0, msrb_pkg::A_FEAT1, 16'h0000);
		rd(1'b1, msrb_pkg::A_FEAT2, 16'h0000);
		rd(1'b0, msrb_pkg::A_R48, 16'h0064);
		rd(1'b0, msrb_pkg::A_R50, 16'h0190);
		rd(1'b1, msrb_pkg::A_R51, 16'h0004);
	endtask
	task automatic s_preset();
		wr(1'b1, msrb_pkg::A_PRESET, 16'h0abc);
		chan_in[1].status_byte = 8'h5a;
		chan_in[1].ctrl_byte[1] = 1'b1;
		// The load pulse stands for exactly the cycle after the edge.
		@(negedge core_clk);
		chk({15'h0, chan_out[1].cnt_load}, 16'h0001);
		chk(chan_out[1].cnt_val, 16'h0abc);
		rd(1'b1, msrb_pkg::A_STATUS, 16'h005a);
		chan_in[1].ctrl_byte[1] = 1'b0;
	endtask
	task automatic s_drive();
		wr(1'b0, msrb_pkg::A_FEAT1, 16'h0204);
		wr(1'b1, msrb_pkg::A_FEAT1, 16'h0400);
		wr(1'b0, msrb_pkg::A_CMD, 16'h8000);
		chk({15'h0, chan_out[0].motor_off}, 16'h0001);
		chk({14'h0, chan_out[0].drv_reinit, chan_out[0].chan_off}, 16'h0003);
		chan_in[0] = '{overload: 1'b1, ctrl_byte: 8'h01, default: '0};
		chan_in[1] = '{overload: 1'b1, auto_req: 1'b1, default: '0};
		// Long enough for the quiet time plus a full watchdog span.
		repeat (80) @(negedge core_clk);
		chk({15'h0, chan_out[1].overload_warn}, 16'h0001);
		chk({14'h0, chan_out[1].torque_cut, chan_out[0].torque_cut}, 16'h0003);
		chan_in[0].overload = 1'b0;
		chan_in[1].overload = 1'b0;
		repeat (2) @(negedge core_clk);
		chk({14'h0, chan_out[0].fault, chan_out[0].wd_trip}, 16'h0002);
		chk({15'h0, chan_out[1].wd_trip}, 16'h0001);
		wr(1'b0, msrb_pkg::A_CMD, 16'h8000);
		chk({15'h0, chan_out[0].fault}, 16'h0000);
		// Kicks hold the count through the quiet time, then the timeout runs from zero.
		wr(1'b0, msrb_pkg::A_FEAT1, 16'h0000);
		chan_in[0].wd_kick = 1'b1;
		repeat (20) @(negedge core_clk);
		chan_in[0].wd_kick = 1'b0;
		repeat (WD_SIM - 1) @(negedge core_clk);
		chk({15'h0, chan_out[0].wd_trip}, 16'h0000);
		@(negedge core_clk);
		chk({15'h0, chan_out[0].wd_trip}, 16'h0001);
	endtask
	initial begin
		err_total = 0;
		checks = 0;
		reset = 1'b1;
		for (i = 0; i < 15; i++) meas.val[i] = 16'h1000 + 16'(i);
		meas.drv_fw = 16'h3242;
		factory = '{hw_rev: 16'h0003, link_freq: 16'h0020, default: 16'h0055};
		chan_in[0] = '0;
		chan_in[1] = '0;
		do_reset();
		s_lock();
		i_host.unlock(1'b0);
		i_host.unlock(1'b1);
		s_ro();
		s_sel();
		s_page();
		s_feat();
		s_preset();
		s_drive();
		do_reset();
		s_lock();
		results();
	end
	initial begin
		#100us;
		err_total++;
		results();
	end
endmodule
